// [cpu_branch_bit_xor_swap_ops.sv]
`timescale 1ns/1ps
`include "exec_map.svh"
module cpu_branch_bit_xor_swap_ops
#(
   parameter int IP_W = `IP_W_DEF
)
(
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic instr_valid_i,
   input wire exec_pkg::op_type op_i,
   input wire logic [`FILE_AW-1:0] file_addr_i,
   input wire logic [`BIT_W-1:0] bit_sel_i,
   input wire logic dest_sel_i,
   input wire logic [`ACC_W-1:0] literal_i,
   input wire logic [`FILE_AW-1:0] peek_addr_i,
   output logic busy_o,
   output logic [IP_W-1:0] ip_o,
   output logic [`ACC_W-1:0] acc_o,
   output logic zero_o,
   output logic [`ACC_W-1:0] port_one_direction_o,
   output logic [`ACC_W-1:0] port_two_direction_o,
   output logic [`ACC_W-1:0] port_three_direction_o,
   output logic bad_operand_o,
   output logic [`ACC_W-1:0] peek_data_o
);
   import exec_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // parameter check: the pointer must be at least one bit wider than the accumulator
   generate
      if (IP_W < `ACC_W + 1)
      begin : g_bad_ip_w
         $error("instruction pointer width too small");
      end
   endgenerate

   // pointer advance, used for the plain step and for the computed jump
   function automatic logic [IP_W-1:0] ip_add(input logic [IP_W-1:0] base,
                                              input logic [`ACC_W-1:0] off);
      ip_add = base + IP_W'(1) + IP_W'(off);
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // state
   logic busy_r;
   logic [IP_W-1:0] ip_r;
   logic [`ACC_W-1:0] acc_r;
   logic zero_r;
   logic [`ACC_W-1:0] dir_one_r;
   logic [`ACC_W-1:0] dir_two_r;
   logic [`ACC_W-1:0] dir_three_r;
   logic bad_r;
   logic [`ACC_W-1:0] peek_r;
   logic [`ACC_W-1:0] file_mem [0:(1<<`FILE_AW)-1];

   alu_link lnk_i();

   alu_unit u_alu
   (
      .lnk(lnk_i)
   );

   ////////////////////////////////////////////////////////////////////////////
   // decode: an instruction is taken only while no jump is finishing
   wire accept;
   wire is_jump;
   wire is_set;
   wire is_swap;
   wire is_ximm;
   wire is_xreg;
   wire is_dir;
   wire to_file;
   wire acc_we;
   wire file_we;
   wire zero_we;
   wire dir_ok;
   wire [`ACC_W-1:0] fdata;
   wire [IP_W-1:0] ip_nxt;

   assign accept = instr_valid_i & ~busy_r;
   assign is_jump = accept & (op_i == computed_relative_jump);
   assign is_set = accept & (op_i == set_single_position);
   assign is_swap = accept & (op_i == nibble_exchange_op);
   assign is_ximm = accept & (op_i == xor_immediate_op);
   assign is_xreg = accept & (op_i == xor_register_op);
   assign is_dir = accept & (op_i == direction_load_op);
   assign to_file = (dest_sel_i == `DEST_FILE);
   assign acc_we = is_ximm | ((is_swap | is_xreg) & ~to_file);
   assign file_we = is_set | ((is_swap | is_xreg) & to_file);
   // only the xor ops touch the zero flag; jump, set, swap, load keep it
   assign zero_we = is_ximm | is_xreg;
   assign dir_ok = (file_addr_i >= `DIR_SEL_ONE) && (file_addr_i <= `DIR_SEL_THREE);
   assign fdata = file_mem[file_addr_i];
   // jump lands on pointer plus one plus unsigned acc; others step by one
   assign ip_nxt = is_jump ? ip_add(ip_r, acc_r) : ip_add(ip_r, `ACC_W'(0));

   assign lnk_i.op = op_i;
   assign lnk_i.acc = acc_r;
   assign lnk_i.fdata = fdata;
   assign lnk_i.literal = literal_i;
   assign lnk_i.bit_sel = bit_sel_i;

   ////////////////////////////////////////////////////////////////////////////
   // pointer and jump stall: the second jump cycle refuses new instructions
   always_ff @(posedge clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         busy_r <= 1'b0;
         ip_r <= IP_W'(`IP_RST);
      end
      else
      begin
         busy_r <= is_jump;
         if (accept)
         begin
            ip_r <= ip_nxt;
         end
      end
   end

   // accumulator and zero flag
   always_ff @(posedge clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         acc_r <= `ACC_RST;
         zero_r <= 1'b0;
      end
      else
      begin
         if (acc_we)
         begin
            acc_r <= lnk_i.result;
         end
         if (zero_we)
         begin
            zero_r <= lnk_i.zero;
         end
      end
   end

   // direction registers; an operand outside 5..7 loads nothing and is flagged
   always_ff @(posedge clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         dir_one_r <= `DIR_RST;
         dir_two_r <= `DIR_RST;
         dir_three_r <= `DIR_RST;
         bad_r <= 1'b0;
      end
      else
      begin
         bad_r <= is_dir & ~dir_ok;
         if (is_dir && file_addr_i == `DIR_SEL_ONE)
         begin
            dir_one_r <= acc_r;
         end
         if (is_dir && file_addr_i == `DIR_SEL_TWO)
         begin
            dir_two_r <= acc_r;
         end
         if (is_dir && file_addr_i == `DIR_SEL_THREE)
         begin
            dir_three_r <= acc_r;
         end
      end
   end

   // file registers carry data only, so they are not reset (saves area)
   always_ff @(posedge clk_i)
   begin
      if (file_we)
      begin
         file_mem[file_addr_i] <= lnk_i.result;
      end
      peek_r <= file_mem[peek_addr_i];
   end

   assign busy_o = busy_r;
   assign ip_o = ip_r;
   assign acc_o = acc_r;
   assign zero_o = zero_r;
   assign port_one_direction_o = dir_one_r;
   assign port_two_direction_o = dir_two_r;
   assign port_three_direction_o = dir_three_r;
   assign bad_operand_o = bad_r;
   assign peek_data_o = peek_r;

   ////////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!rst_b_i);

   sequence jump_take;
      is_jump;
   endsequence

   sequence jump_hold;
      busy_o ##1 !busy_o;
   endsequence

   jump_target_a: assert property (jump_take |=>
      ip_o == IP_W'($past(ip_o) + IP_W'(1) + IP_W'($past(acc_o))))
      else $error("jump target wrong");
   jump_cycles_a: assert property (jump_take |=> jump_hold)
      else $error("jump not two cycles");
   jump_flags_a: assert property (jump_take |=>
      $stable(zero_o) ##1 $stable(zero_o) && $stable(ip_o))
      else $error("jump disturbed state");
   // file registers start unknown, so untouched bits are compared case-exact
   bit_set_a: assert property (is_set |=>
      file_mem[$past(file_addr_i)] === ($past(fdata) | (`ACC_W'(1) << $past(bit_sel_i)))
      && $stable(zero_o))
      else $error("bit set wrong");
   bit_one_a: assert property (is_set |=>
      file_mem[$past(file_addr_i)][$past(bit_sel_i)] == 1'b1)
      else $error("chosen bit not set");
   swap_acc_a: assert property (is_swap && !to_file |=>
      acc_o == {$past(fdata[`NIB_LO_MSB:0]), $past(fdata[`ACC_W-1:`NIB_HI_LSB])}
      && $stable(zero_o))
      else $error("swap to acc wrong");
   swap_file_a: assert property (is_swap && to_file |=>
      $stable(acc_o)
      && file_mem[$past(file_addr_i)]
         == {$past(fdata[`NIB_LO_MSB:0]), $past(fdata[`ACC_W-1:`NIB_HI_LSB])})
      else $error("swap to file wrong");
   xor_imm_a: assert property (is_ximm |=>
      acc_o == ($past(acc_o) ^ $past(literal_i)) && zero_o == (acc_o == `ACC_W'(0)))
      else $error("literal xor wrong");
   xor_reg_zero_a: assert property (is_xreg |=>
      zero_o == (($past(acc_o) ^ $past(fdata)) == `ACC_W'(0)))
      else $error("register xor zero wrong");
   xor_reg_dest_a: assert property (is_xreg && to_file |=>
      $stable(acc_o) && file_mem[$past(file_addr_i)] == ($past(acc_o) ^ $past(fdata)))
      else $error("register xor route wrong");
   xor_reg_acc_a: assert property (is_xreg && !to_file |=>
      acc_o == ($past(acc_o) ^ $past(fdata)))
      else $error("register xor to acc wrong");
   dir_load_a: assert property (is_dir && file_addr_i == `DIR_SEL_TWO |=>
      port_two_direction_o == $past(acc_o) && $stable(port_one_direction_o)
      && $stable(zero_o))
      else $error("direction load wrong");
endmodule

// [exec_map.svh]
`ifndef EXEC_MAP_SVH
`define EXEC_MAP_SVH

// data path and file sizes
`define ACC_W 8
`define FILE_AW 7
`define BIT_W 3
`define NIB_LO_MSB 3
`define NIB_HI_LSB 4
`define IP_W_DEF 15

// direction-load operand values
`define DIR_SEL_ONE 7'h05
`define DIR_SEL_TWO 7'h06
`define DIR_SEL_THREE 7'h07

// destination select encoding
`define DEST_ACC 1'b0
`define DEST_FILE 1'b1

// reset values
`define ACC_RST 8'h00
`define DIR_RST 8'hff
`define IP_RST 15'h0000

// timing: the computed jump holds the core for this many instruction cycles
`define JUMP_CYCLES 2

`endif

// [exec_pkg.sv]
package exec_pkg;
   // operation selected by the decoder for this execution unit
   typedef enum logic [2:0]
   {
      op_idle,
      computed_relative_jump,
      set_single_position,
      nibble_exchange_op,
      xor_immediate_op,
      xor_register_op,
      direction_load_op
   } op_type;
endpackage

// [alu_link.sv]
`timescale 1ns/1ps
`include "exec_map.svh"
interface alu_link;
   import exec_pkg::*;
   op_type op;
   logic [`ACC_W-1:0] acc;
   logic [`ACC_W-1:0] fdata;
   logic [`ACC_W-1:0] literal;
   logic [`BIT_W-1:0] bit_sel;
   logic [`ACC_W-1:0] result;
   logic zero;
   modport core (output op, acc, fdata, literal, bit_sel, input result, zero);
   modport alu (input op, acc, fdata, literal, bit_sel, output result, zero);
endinterface

// [alu_unit.sv]
`timescale 1ns/1ps
`include "exec_map.svh"
module alu_unit
(
   alu_link.alu lnk
);
   import exec_pkg::*;

   wire [`ACC_W-1:0] set_mask;
   wire [`ACC_W-1:0] swap_val;
   wire [`ACC_W-1:0] xor_imm_val;
   wire [`ACC_W-1:0] xor_reg_val;
   logic [`ACC_W-1:0] res;

   // one-hot mask so only the chosen bit is forced high
   assign set_mask = `ACC_W'(1) << lnk.bit_sel;
   assign swap_val = {lnk.fdata[`NIB_LO_MSB:0], lnk.fdata[`ACC_W-1:`NIB_HI_LSB]};
   assign xor_imm_val = lnk.acc ^ lnk.literal;
   assign xor_reg_val = lnk.acc ^ lnk.fdata;

   // result select; ops without a data result pass the accumulator
   always_comb
   begin
      case (lnk.op)
         set_single_position: res = lnk.fdata | set_mask;
         nibble_exchange_op: res = swap_val;
         xor_immediate_op: res = xor_imm_val;
         xor_register_op: res = xor_reg_val;
         default: res = lnk.acc;
      endcase
   end

   assign lnk.result = res;
   assign lnk.zero = (res == `ACC_W'(0));
endmodule

// [tb_cpu_branch_bit_xor_swap_ops.sv]
`timescale 1ns/1ps
module tb_cpu_branch_bit_xor_swap_ops;
   import exec_pkg::*;
   localparam int IP_W = 15;
   logic clk_i = 1'b0;
   logic rst_b_i = 1'b0;
   logic instr_valid_i = 1'b0;
   op_type op_i = op_idle;
   logic [6:0] file_addr_i = 7'h00;
   logic [2:0] bit_sel_i = 3'h0;
   logic dest_sel_i = 1'b0;
   logic [7:0] literal_i = 8'h00;
   logic [6:0] peek_addr_i = 7'h00;
   logic busy_o;
   logic [IP_W-1:0] ip_o;
   logic [7:0] acc_o;
   logic zero_o;
   logic [7:0] port_one_direction_o;
   logic [7:0] port_two_direction_o;
   logic [7:0] port_three_direction_o;
   logic bad_operand_o;
   logic [7:0] peek_data_o;
   int failures = 0;
   int n_compared = 0;
   logic [IP_W-1:0] exp_ip = {IP_W{1'b0}};
   logic [7:0] exp_acc = 8'h00;
   logic exp_z = 1'b0;

   // free-running instruction clock, 100 ns period
   always #50 clk_i = ~clk_i;

   cpu_branch_bit_xor_swap_ops #(.IP_W(IP_W)) dut (
      .clk_i(clk_i), .rst_b_i(rst_b_i), .instr_valid_i(instr_valid_i), .op_i(op_i),
      .file_addr_i(file_addr_i), .bit_sel_i(bit_sel_i), .dest_sel_i(dest_sel_i),
      .literal_i(literal_i), .peek_addr_i(peek_addr_i), .busy_o(busy_o), .ip_o(ip_o),
      .acc_o(acc_o), .zero_o(zero_o), .port_one_direction_o(port_one_direction_o),
      .port_two_direction_o(port_two_direction_o),
      .port_three_direction_o(port_three_direction_o),
      .bad_operand_o(bad_operand_o), .peek_data_o(peek_data_o));

   ////////////////////////////////////////////////////////////////////////////////
   // shared helpers: compare, issue one instruction, read back a file register
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         failures++;
         $display("[ERR] %0t ns: got %h expected %h", $time, seen, exp);
      end
   endtask

   // drives after an edge, drops valid at the taking edge; results are settled on return
   task automatic issue(input op_type op, input logic [6:0] f, input logic [2:0] b,
                        input logic d, input logic [7:0] k);
      @(posedge clk_i);
      instr_valid_i <= 1'b1;
      op_i <= op;
      file_addr_i <= f;
      bit_sel_i <= b;
      dest_sel_i <= d;
      literal_i <= k;
      @(posedge clk_i);
      instr_valid_i <= 1'b0;
      #1;
      exp_ip = exp_ip + 1'b1;
      check(ip_o, exp_ip);
   endtask

   task automatic set_acc(input logic [7:0] v);
      issue(xor_immediate_op, 7'h00, 3'h0, 1'b0, exp_acc ^ v);
      exp_acc = v;
      exp_z = (v == 8'h00);
   endtask

   // peek address is driven after one edge, captured at the next, data shows right after that edge
   task automatic peek(input logic [6:0] f);
      @(posedge clk_i);
      peek_addr_i <= f;
      @(posedge clk_i);
      #1;
   endtask

   task automatic print_verdict();
      $display("compared %0d, mismatches %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // scenarios
   task automatic xor_imm_test();
      logic [7:0] lits [4] = '{8'h5a, 8'h5a, 8'hff, 8'h01};
      for (int i = 0; i < 4; i++)
      begin
         issue(xor_immediate_op, 7'h00, 3'h0, 1'b1, lits[i]);
         exp_acc = exp_acc ^ lits[i];
         exp_z = (exp_acc == 8'h00);
         check(acc_o, exp_acc);
         check(zero_o, exp_acc == 8'h00);
      end
      $display("test xor_imm done");
   endtask

   // memory is not reset, so the top file register is built to 0xff one bit at a time
   task automatic file_test();
      for (int b = 0; b < 8; b++)
      begin
         issue(set_single_position, 7'h7f, 3'(b), 1'b0, 8'h00);
         check(zero_o, exp_z);
         peek(7'h7f);
         check(peek_data_o[b], 1'b1);
      end
      check(peek_data_o, 8'hff);
      set_acc(8'h3c);
      issue(xor_register_op, 7'h7f, 3'h0, 1'b1, 8'h00);
      check(acc_o, 8'h3c);
      check(zero_o, 1'b0);
      peek(7'h7f);
      check(peek_data_o, 8'hc3);
      issue(xor_register_op, 7'h7f, 3'h0, 1'b0, 8'h00);
      check(acc_o, 8'hff);
      exp_acc = 8'hff;
      exp_z = 1'b0;
      set_acc(8'hc3);
      issue(xor_register_op, 7'h7f, 3'h0, 1'b0, 8'h00);
      exp_acc = 8'h00;
      exp_z = 1'b1;
      check(acc_o, 8'h00);
      check(zero_o, 1'b1);
      issue(nibble_exchange_op, 7'h7f, 3'h0, 1'b0, 8'h00);
      exp_acc = 8'h3c;
      check(acc_o, 8'h3c);
      check(zero_o, 1'b1);
      issue(nibble_exchange_op, 7'h7f, 3'h0, 1'b1, 8'h00);
      check(acc_o, 8'h3c);
      peek(7'h7f);
      check(peek_data_o, 8'h3c);
      $display("test file ops done");
   endtask

   task automatic dir_test();
      logic [7:0] v [3] = '{8'ha5, 8'h3c, 8'h81};
      for (int i = 0; i < 3; i++)
      begin
         set_acc(v[i]);
         issue(direction_load_op, 7'(5 + i), 3'h0, 1'b0, 8'h00);
         check(bad_operand_o, 1'b0);
      end
      check(port_one_direction_o, v[0]);
      check(port_two_direction_o, v[1]);
      check(port_three_direction_o, v[2]);
      set_acc(8'h00);
      issue(direction_load_op, 7'h04, 3'h0, 1'b0, 8'h00);
      check(bad_operand_o, 1'b1);
      check(port_one_direction_o, v[0]);
      check(zero_o, 1'b1);
      @(posedge clk_i);
      #1;
      check(bad_operand_o, 1'b0);
      $display("test direction load done");
   endtask

   // an instruction offered in the busy cycle must leave no trace
   task automatic jump_test();
      logic [IP_W-1:0] tgt;
      set_acc(8'hf0);
      tgt = exp_ip + 1'b1 + {{(IP_W-8){1'b0}}, exp_acc};
      @(posedge clk_i);
      instr_valid_i <= 1'b1;
      op_i <= computed_relative_jump;
      @(posedge clk_i);
      op_i <= xor_immediate_op;
      literal_i <= 8'hff;
      #1;
      check(ip_o, tgt);
      check(busy_o, 1'b1);
      @(posedge clk_i);
      instr_valid_i <= 1'b0;
      #1;
      check(busy_o, 1'b0);
      check(ip_o, tgt);
      check(acc_o, exp_acc);
      check(zero_o, exp_z);
      exp_ip = tgt;
      $display("test jump done");
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // main sequence
   initial
   begin
      repeat (12) @(posedge clk_i);
      rst_b_i <= 1'b1;
      #1;
      check(acc_o, 8'h00);
      check(zero_o, 1'b0);
      check(busy_o, 1'b0);
      check(ip_o, 16'h0000);
      check(port_three_direction_o, 8'hff);
      xor_imm_test();
      file_test();
      dir_test();
      jump_test();
      print_verdict();
   end
endmodule
